// ### pkg/vcu_consts.svh
/*
 Constants of the serial link: register offsets, field positions,
 reset values and bit timing. Assumes a 250 MHz pclk.
*/
// Function
// - Target sends characters on transmit line.
// - Board sends on receive line; target samples.
// - Board asserts clear-to-send while it has room.
// - Target asserts request-to-send only with receive room.
// - Data passes only while link enable active.
// - Four serial lines plus one enable.
// - Reset: 115200, eight_data_no_parity_one_stop, handshake off.
// - Bit rate 9600 to 921600, same both ends.
// - Handshake selectable separately per direction.
// - Board stops sending while request-to-send deasserted.
// - Target takes one more character after deasserting.
// - Target transmitter halts while clear-to-send deasserted.
`ifndef VCU_CONSTS_SVH
`define VCU_CONSTS_SVH

// ==========================================================
// Timing
`define VCU_CLK_HZ 250000000
`define VCU_BAUD_RESET 115200
`define VCU_BAUD_MIN 9600
`define VCU_BAUD_MAX 921600
`define VCU_DIV_RESET (`VCU_CLK_HZ / `VCU_BAUD_RESET)
`define VCU_DIV_MIN (`VCU_CLK_HZ / `VCU_BAUD_MAX)
`define VCU_DIV_MAX (`VCU_CLK_HZ / `VCU_BAUD_MIN)
`define VCU_DATA_BITS 8

// ==========================================================
// Register offsets
`define VCU_OFF_CTRL 12'h000
`define VCU_OFF_BAUD 12'h004
`define VCU_OFF_TXD 12'h008
`define VCU_OFF_RXD 12'h00c
`define VCU_OFF_STAT 12'h010

// ==========================================================
// Fields
`define VCU_CTRL_EN 0
`define VCU_CTRL_TXHS 1
`define VCU_CTRL_RXHS 2
`define VCU_CTRL_RESET 3'h0
`define VCU_ST_TXBUSY 0
`define VCU_ST_TXFULL 1
`define VCU_ST_RXAVAIL 2
`define VCU_ST_RXERR 3
`define VCU_ST_PEER 4
`define VCU_ST_ROOM 5
`define VCU_ST_LINK 6

`endif

// ### pkg/vcu_link_if.sv
/*
 The four serial lines and the enable between the two ends.
 Assumes the bench joins a target end and a board end through it.
*/
`default_nettype none
interface vcu_link_if;
    logic tx;
    logic rx;
    logic cts;
    logic rts;
    logic en;
    modport target (output tx, output rts, output en, input rx, input cts);
    modport board (input tx, input rts, input en, output rx, output cts);
endinterface : vcu_link_if
`default_nettype wire

// ### pkg/vcu_pkg.sv
/*
 Types of the serial link ends.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package vcu_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} vcu_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} vcu_rx_state_t;
endpackage : vcu_pkg
`default_nettype wire

// ### rtl/vcu_board_end.sv
/*
 Board controller end of the serial link.
 Assumes vcu_port from the target end file is compiled first.
*/
`include "vcu_consts.svh"
`default_nettype none

module vcu_board_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    vcu_link_if.board link
);
    import vcu_pkg::*;

    // ======================================================
    // Enable pin synchroniser
    logic e1_ff, e2_ff, e3_ff, en_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            e1_ff <= 1'b0;
            e2_ff <= 1'b0;
            e3_ff <= 1'b0;
            en_ff <= 1'b0;
        end
        else
        begin
            e1_ff <= link.en;
            e2_ff <= e1_ff;
            e3_ff <= e2_ff;
            if (e2_ff == e3_ff)
                en_ff <= e3_ff;
        end
    end

    // Own enable bit unused: the target owns the link enable
    vcu_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .link_on(en_ff),
        .rx_pin(link.tx),
        .peer_ok_pin(link.rts),
        .tx_line(link.rx),
        .room(link.cts),
        .ctrl_link_en()
    );
endmodule : vcu_board_end

`default_nettype wire

// ### rtl/vcu_target_end.sv
/*
 Shared link port (APB registers, transmitter, receiver, flow control)
 and the target end built on it.
 Assumes one pclk domain; the link lines come in asynchronously.
*/
// The register addresses and the APB slave port are this design's own decisions.
`include "vcu_consts.svh"
`default_nettype none

module vcu_port #(
    parameter logic [15:0] DIV_RESET = 16'(`VCU_DIV_RESET)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_on,
    input wire logic rx_pin,
    input wire logic peer_ok_pin,
    output logic tx_line,
    output logic room,
    output logic ctrl_link_en
);
    import vcu_pkg::*;

    // ======================================================
    // Pin synchronisers
    wire [1:0] raw = {peer_ok_pin, rx_pin};
    logic [1:0] s1_ff, s2_ff, s3_ff, flt_ff;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_ff[gi] <= 1'b1;
                    s2_ff[gi] <= 1'b1;
                    s3_ff[gi] <= 1'b1;
                    flt_ff[gi] <= 1'b1;
                end
                else
                begin
                    s1_ff[gi] <= raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi])
                        flt_ff[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate
    wire rx_s = flt_ff[0];
    wire peer_s = flt_ff[1];

    // ======================================================
    // Register decode
    logic [2:0] ctrl_ff;
    logic [15:0] baud_ff;
    logic rx_err_ff;
    logic [7:0] tx_hold_ff;
    logic tx_hold_vld_ff;
    logic [7:0] rx_buf_ff [2];
    logic rx_head_ff;
    logic [1:0] rx_cnt_ff;
    logic [31:0] prdata_ff;
    vcu_tx_state_t tx_st_ff;
    wire setup = psel & ~penable;
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire sel_ctrl = paddr == `VCU_OFF_CTRL;
    wire sel_baud = paddr == `VCU_OFF_BAUD;
    wire sel_txd = paddr == `VCU_OFF_TXD;
    wire sel_rxd = paddr == `VCU_OFF_RXD;
    wire sel_stat = paddr == `VCU_OFF_STAT;
    wire hit = sel_ctrl | sel_baud | sel_txd | sel_rxd | sel_stat;
    wire baud_ok = pwdata >= 32'(`VCU_DIV_MIN) && pwdata <= 32'(`VCU_DIV_MAX);
    wire tx_wr = wr & sel_txd & ~tx_hold_vld_ff;
    wire rx_pop = rd & sel_rxd & (rx_cnt_ff != 2'h0);
    wire bad = (wr & sel_txd & tx_hold_vld_ff) | (wr & sel_baud & ~baud_ok);
    wire [6:0] stat = {link_on, room, peer_s, rx_err_ff, rx_cnt_ff != 2'h0,
                       tx_hold_vld_ff, tx_st_ff != TX_IDLE};
    wire [31:0] rd_mux = sel_ctrl ? {29'h0, ctrl_ff} :
                         sel_baud ? {16'h0, baud_ff} :
                         sel_rxd ? {24'h0, rx_buf_ff[rx_head_ff]} :
                         sel_stat ? {25'h0, stat} : 32'h0;
    // Data latched in setup so prdata is a flop and pready needs no wait
    assign pready = 1'b1;
    assign pslverr = acc & (~hit | bad);
    assign prdata = prdata_ff;
    assign ctrl_link_en = ctrl_ff[`VCU_CTRL_EN];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= `VCU_CTRL_RESET;
            baud_ff <= DIV_RESET;
            prdata_ff <= 32'h0;
        end
        else
        begin
            if (setup)
                prdata_ff <= rd_mux;
            if (wr & sel_ctrl)
                ctrl_ff <= pwdata[2:0];
            if (wr & sel_baud & baud_ok)
                baud_ff <= pwdata[15:0];
        end
    end

    // ======================================================
    // Transmitter
    logic [15:0] tx_cnt_ff;
    logic [2:0] tx_bit_ff;
    logic [7:0] tx_sh_ff;
    logic tx_line_ff;
    wire tx_tick = tx_cnt_ff == baud_ff - 16'h1;
    // Permission looked at only when idle, so a started character always ends
    wire tx_go = link_on & tx_hold_vld_ff & (~ctrl_ff[`VCU_CTRL_TXHS] | peer_s);
    assign tx_line = tx_line_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st_ff <= TX_IDLE;
            tx_cnt_ff <= 16'h0;
            tx_bit_ff <= 3'h0;
            tx_sh_ff <= 8'h0;
            tx_line_ff <= 1'b1;
            tx_hold_ff <= 8'h0;
            tx_hold_vld_ff <= 1'b0;
        end
        else
        begin
            tx_cnt_ff <= (tx_st_ff == TX_IDLE || tx_tick) ? 16'h0 : tx_cnt_ff + 16'h1;
            if (tx_wr)
            begin
                tx_hold_ff <= pwdata[7:0];
                tx_hold_vld_ff <= 1'b1;
            end
            unique case (tx_st_ff)
                TX_IDLE:
                    if (tx_go)
                    begin
                        tx_sh_ff <= tx_hold_ff;
                        tx_hold_vld_ff <= 1'b0;
                        tx_line_ff <= 1'b0;
                        tx_st_ff <= TX_START;
                    end
                TX_START:
                    if (tx_tick)
                    begin
                        tx_line_ff <= tx_sh_ff[0];
                        tx_bit_ff <= 3'h0;
                        tx_st_ff <= TX_DATA;
                    end
                TX_DATA:
                    if (tx_tick)
                    begin
                        tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                        tx_bit_ff <= tx_bit_ff + 3'h1;
                        tx_line_ff <= (tx_bit_ff == 3'(`VCU_DATA_BITS - 1)) ? 1'b1 : tx_sh_ff[1];
                        if (tx_bit_ff == 3'(`VCU_DATA_BITS - 1))
                            tx_st_ff <= TX_STOP;
                    end
                TX_STOP:
                    if (tx_tick)
                        tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    // ======================================================
    // Receiver
    vcu_rx_state_t rx_st_ff;
    logic [15:0] rx_cnt_t_ff;
    logic [2:0] rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic rx_done_ff;
    logic rx_bad_ff;
    wire rx_tick = rx_cnt_t_ff == baud_ff - 16'h1;
    wire rx_half = rx_cnt_t_ff == {1'b0, baud_ff[15:1]};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_ff <= RX_IDLE;
            rx_cnt_t_ff <= 16'h0;
            rx_bit_ff <= 3'h0;
            rx_sh_ff <= 8'h0;
            rx_done_ff <= 1'b0;
            rx_bad_ff <= 1'b0;
        end
        else
        begin
            rx_done_ff <= 1'b0;
            rx_bad_ff <= 1'b0;
            rx_cnt_t_ff <= rx_cnt_t_ff + 16'h1;
            unique case (rx_st_ff)
                RX_IDLE:
                begin
                    rx_cnt_t_ff <= 16'h0;
                    if (link_on & ~rx_s)
                        rx_st_ff <= RX_START;
                end
                RX_START:
                    if (rx_half)
                    begin
                        rx_cnt_t_ff <= 16'h0;
                        rx_bit_ff <= 3'h0;
                        // A high mid-start is a glitch, not a character
                        rx_st_ff <= rx_s ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_cnt_t_ff <= 16'h0;
                        rx_sh_ff <= {rx_s, rx_sh_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == 3'(`VCU_DATA_BITS - 1))
                            rx_st_ff <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_tick)
                    begin
                        rx_done_ff <= rx_s;
                        rx_bad_ff <= ~rx_s;
                        rx_st_ff <= RX_IDLE;
                    end
            endcase
        end
    end

    // ======================================================
    // Two-slot receive store
    // Room drops at one held byte so the second slot takes the one in flight
    wire rx_push = rx_done_ff & (rx_cnt_ff != 2'h2 | rx_pop);
    wire rx_tail = rx_head_ff ^ rx_cnt_ff[0];
    assign room = ~ctrl_ff[`VCU_CTRL_RXHS] | (rx_cnt_ff == 2'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_buf_ff[0] <= 8'h0;
            rx_buf_ff[1] <= 8'h0;
            rx_head_ff <= 1'b0;
            rx_cnt_ff <= 2'h0;
            rx_err_ff <= 1'b0;
        end
        else
        begin
            // Tail is the free slot whether or not the head pops this cycle
            if (rx_push)
                rx_buf_ff[rx_tail] <= rx_sh_ff;
            if (rx_pop)
                rx_head_ff <= ~rx_head_ff;
            rx_cnt_ff <= rx_cnt_ff + {1'b0, rx_push} - {1'b0, rx_pop};
            // Overrun or framing error; a new event wins over the clear
            if (rx_bad_ff | (rx_done_ff & ~rx_push))
                rx_err_ff <= 1'b1;
            else if (wr & sel_stat & pwdata[`VCU_ST_RXERR])
                rx_err_ff <= 1'b0;
        end
    end
endmodule : vcu_port

// ==========================================================
// Target end
module vcu_target_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    vcu_link_if.target link
);
    import vcu_pkg::*;
    logic en;

    vcu_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .link_on(en),
        .rx_pin(link.rx),
        .peer_ok_pin(link.cts),
        .tx_line(link.tx),
        .room(link.rts),
        .ctrl_link_en(en)
    );
    assign link.en = en;
endmodule : vcu_target_end

`default_nettype wire

// ### verification/tb.sv
/*
 Bench joining a target end and a board end through the link interface.
 Assumes both ends answer APB at once and share one 250 MHz pclk.
*/
`include "vcu_consts.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] m; logic e;} vcu_note_t;
    localparam int BIT = `VCU_DIV_MIN;
    logic pclk;
    logic presetn;
    logic psel [2];
    logic penable [2];
    logic pwrite [2];
    logic [11:0] paddr [2];
    logic [31:0] pwdata [2];
    logic [31:0] prdata [2];
    logic pready [2];
    logic pslverr [2];
    vcu_note_t q [2][$];
    int err_count;
    int n_checks;
    int seed;
    logic [7:0] b [6];

    vcu_link_if link();
    vcu_target_end vcu_target_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel[0]),
        .penable(penable[0]), .pwrite(pwrite[0]), .paddr(paddr[0]), .pwdata(pwdata[0]),
        .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]), .link(link));
    vcu_board_end vcu_board_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel[1]),
        .penable(penable[1]), .pwrite(pwrite[1]), .paddr(paddr[1]), .pwdata(pwdata[1]),
        .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]), .link(link));
    vcu_link_checker vcu_link_checker_inst (.pclk(pclk), .presetn(presetn), .tx(link.tx),
        .rx(link.rx), .cts(link.cts), .rts(link.rts), .en(link.en));

    // ==========================================================
    // APB master, side 0 target, side 1 board
    task automatic apb(input int s, input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel[s] <= 1'b1;
        pwrite[s] <= w;
        paddr[s] <= a;
        pwdata[s] <= d;
        @(posedge pclk);
        penable[s] <= 1'b1;
        @(posedge pclk);
        while (pready[s] !== 1'b1)
            @(posedge pclk);
        psel[s] <= 1'b0;
        penable[s] <= 1'b0;
    endtask : apb

    task automatic rd(input int s, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e = 1'b0);
        q[s].push_back('{a, d, m, e});
        apb(s, 1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input int s, input logic [11:0] a, input logic [31:0] d,
                      input logic e = 1'b0);
        q[s].push_back('{a, 32'h0, 32'h0, e});
        apb(s, 1'b1, a, d);
    endtask : wr

    task automatic bits(input int n);
        repeat (n * BIT) @(posedge pclk);
    endtask : bits

    // ==========================================================
    // Result watcher
    always @(posedge pclk)
    begin
        for (int s = 0; s < 2; s++)
        begin
            if (psel[s] === 1'b1 && penable[s] === 1'b1 && pready[s] === 1'b1)
            begin
                vcu_note_t n;
                n = q[s].pop_front();
                n_checks++;
                if ((prdata[s] & n.m) !== n.d || pslverr[s] !== n.e)
                begin
                    $display("[FAIL] side %0d addr %h exp %h/%b seen %h/%b", s, n.a, n.d, n.e,
                             prdata[s] & n.m, pslverr[s]);
                    err_count++;
                end
            end
        end
    end

    task end_sim;
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // Sender obeys room, receiver shows room: second byte must wait for the pop
    task automatic flow(input int s);
        int r;
        r = 1 - s;
        wr(r, `VCU_OFF_CTRL, 32'h7);
        wr(s, `VCU_OFF_CTRL, 32'h3);
        wr(s, `VCU_OFF_TXD, {24'h0, b[4]});
        wr(s, `VCU_OFF_TXD, {24'h0, b[5]});
        bits(25);
        rd(s, `VCU_OFF_STAT, 32'h2, 32'h3);
        rd(r, `VCU_OFF_STAT, 32'h4, 32'h2c);
        rd(r, `VCU_OFF_RXD, {24'h0, b[4]}, 32'hff);
        bits(12);
        rd(r, `VCU_OFF_RXD, {24'h0, b[5]}, 32'hff);
        rd(r, `VCU_OFF_STAT, 32'h20, 32'h2c);
    endtask : flow

    // ==========================================================
    // Clock, watchdog, sequence
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        #400000;
        err_count++;
        end_sim();
    end

    initial
    begin
        presetn = 1'b0;
        err_count = 0;
        n_checks = 0;
        seed = 32'hfa525a3b;
        for (int i = 0; i < 2; i++)
        begin
            psel[i] = 1'b0;
            penable[i] = 1'b0;
            pwrite[i] = 1'b0;
            paddr[i] = 12'h0;
            pwdata[i] = 32'h0;
        end
        for (int i = 0; i < 6; i++)
            b[i] = 8'($random(seed));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            rd(s, `VCU_OFF_CTRL, 32'h0, 32'hffffffff);
            rd(s, `VCU_OFF_BAUD, 32'(`VCU_DIV_RESET), 32'hffffffff);
            rd(s, `VCU_OFF_STAT, 32'h30, 32'h7f);
            rd(s, 12'h014, 32'h0, 32'h0, 1'b1);
            wr(s, `VCU_OFF_BAUD, 32'(`VCU_DIV_MIN - 1), 1'b1);
            wr(s, `VCU_OFF_BAUD, 32'(`VCU_DIV_MAX + 1), 1'b1);
            wr(s, `VCU_OFF_BAUD, 32'(`VCU_DIV_MAX));
            rd(s, `VCU_OFF_BAUD, 32'(`VCU_DIV_MAX), 32'hffffffff);
            wr(s, `VCU_OFF_BAUD, 32'(BIT));
        end
        // Link off holds both bytes back
        wr(0, `VCU_OFF_TXD, {24'h0, b[0]});
        wr(1, `VCU_OFF_TXD, {24'h0, b[1]});
        bits(12);
        rd(1, `VCU_OFF_STAT, 32'h0, 32'h4);
        rd(0, `VCU_OFF_STAT, 32'h2, 32'h47);
        wr(0, `VCU_OFF_CTRL, 32'h1);
        bits(12);
        rd(1, `VCU_OFF_RXD, {24'h0, b[0]}, 32'hff);
        rd(0, `VCU_OFF_RXD, {24'h0, b[1]}, 32'hff);
        rd(0, `VCU_OFF_STAT, 32'h40, 32'h44);
        // Board ignores target room, so the third byte overruns
        wr(0, `VCU_OFF_CTRL, 32'h5);
        wr(1, `VCU_OFF_TXD, {24'h0, b[2]});
        wr(1, `VCU_OFF_TXD, {24'h0, b[3]});
        wr(0, `VCU_OFF_TXD, {24'h0, b[2]});
        wr(0, `VCU_OFF_TXD, {24'h0, b[3]});
        wr(0, `VCU_OFF_TXD, {24'h0, b[4]}, 1'b1);
        bits(12);
        wr(1, `VCU_OFF_TXD, {24'h0, b[4]});
        bits(24);
        rd(0, `VCU_OFF_STAT, 32'hc, 32'hc);
        rd(0, `VCU_OFF_RXD, {24'h0, b[2]}, 32'hff);
        rd(0, `VCU_OFF_RXD, {24'h0, b[3]}, 32'hff);
        wr(0, `VCU_OFF_STAT, 32'h8);
        rd(0, `VCU_OFF_STAT, 32'h20, 32'h2c);
        rd(1, `VCU_OFF_RXD, {24'h0, b[2]}, 32'hff);
        rd(1, `VCU_OFF_RXD, {24'h0, b[3]}, 32'hff);
        flow(0);
        flow(1);
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ### verification/vcu_link_checker.sv
/*
 Checker of the serial lines between the target end and the board end.
 Assumes the bench wires it to the link interface and never drops en mid-frame.
*/
`include "vcu_consts.svh"
`default_nettype none

module vcu_link_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx,
    input wire logic rx,
    input wire logic cts,
    input wire logic rts,
    input wire logic en
);
    localparam int BIT_MIN = `VCU_DIV_MIN;
    localparam int LOW_MAX = 9 * `VCU_DIV_MAX;
    logic [17:0] tx_lo_ff;
    logic [17:0] tx_hi_ff;
    logic [17:0] rx_lo_ff;
    logic [17:0] nxt_tx_lo;
    logic [17:0] nxt_tx_hi;
    logic [17:0] nxt_rx_lo;

    // ==========================================================
    // Run counters
    // Saturating, so a long idle never wraps into a false short run
    assign nxt_tx_lo = tx ? 18'h0 : tx_lo_ff + 18'(tx_lo_ff != 18'h3ffff);
    assign nxt_tx_hi = !tx ? 18'h0 : tx_hi_ff + 18'(tx_hi_ff != 18'h3ffff);
    assign nxt_rx_lo = rx ? 18'h0 : rx_lo_ff + 18'(rx_lo_ff != 18'h3ffff);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_lo_ff <= 18'h0;
            tx_hi_ff <= 18'h3ffff;
            rx_lo_ff <= 18'h0;
        end
        else
        begin
            tx_lo_ff <= nxt_tx_lo;
            tx_hi_ff <= nxt_tx_hi;
            rx_lo_ff <= nxt_rx_lo;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_rst_idle;
        $rose(presetn) |-> tx && rx && cts && rts && !en;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("lines not idle after reset");

    property p_tx_gate;
        $fell(tx) |-> $past(en);
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx moved with link off");

    property p_rx_gate;
        $fell(rx) |-> $past(en);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx moved with link off");

    property p_tx_bit;
        $rose(tx) |-> tx_lo_ff >= BIT_MIN;
    endproperty
    a_tx_bit: assert property (p_tx_bit) else $error("tx low bit too short");

    property p_rx_bit;
        $rose(rx) |-> rx_lo_ff >= BIT_MIN;
    endproperty
    a_rx_bit: assert property (p_rx_bit) else $error("rx low bit too short");

    property p_tx_stop;
        $fell(tx) |-> tx_hi_ff >= BIT_MIN;
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("tx stop or idle too short");

    property p_tx_frame;
        !tx |-> tx_lo_ff < LOW_MAX;
    endproperty
    a_tx_frame: assert property (p_tx_frame) else $error("tx low beyond nine bits");

    property p_rts_drop;
        $fell(rts) |-> rx && $past(rx);
    endproperty
    a_rts_drop: assert property (p_rts_drop) else $error("rts fell outside stop bit");

    property p_cts_drop;
        $fell(cts) |-> tx && $past(tx);
    endproperty
    a_cts_drop: assert property (p_cts_drop) else $error("cts fell outside stop bit");
endmodule : vcu_link_checker
`default_nettype wire
